// >>> shared/asq_pkg.sv
// asq_pkg: constants, register map and types of the analog scan sequencer
package asq_pkg;
  localparam int CLK_NS = 8;
  localparam int CONV_MIN_NS = 8000;
  localparam int BURST_NS = 15000;
  localparam int US_NS = 1000;
  localparam logic [11:0] CONV_MIN_CYC = 12'((CONV_MIN_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] BURST_CYC = 12'((BURST_NS + CLK_NS - 1) / CLK_NS);
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int IVL_MIN_US = 8;
  localparam int IVL_MAX_US = 2090000;
  localparam int IVL_W = 22;
  localparam int NCH = 32;
  localparam int DW = 16;
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_IVL = 12'h004;
  localparam logic [11:0] OFS_CHAN = 12'h008;
  localparam logic [11:0] OFS_NEW = 12'h00C;
  localparam logic [11:0] OFS_MISS = 12'h010;
  localparam logic [11:0] OFS_CMD = 12'h014;
  localparam logic [11:0] OFS_GLO = 12'h018;
  localparam logic [11:0] OFS_GHI = 12'h01C;
  localparam logic [11:0] OFS_IRQ = 12'h020;
  localparam logic [4:0] MBOX_PAGE = 5'h01;
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SE = 3;
  localparam int CTRL_FMT = 4;
  localparam int CTRL_GRP = 5;
  localparam int CTRL_IEN = 6;
  localparam int CTRL_TOUT = 7;
  localparam int CTRL_CAL_LSB = 8;
  localparam int CHAN_END_LSB = 8;
  localparam int CMD_GO = 0;
  localparam int CMD_STOP = 1;
  localparam int IRQ_PEND = 0;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [31:0] IVL_RST = 32'h00000008;
  localparam logic [31:0] CHAN_RST = 32'h00000F00;
  localparam logic [31:0] GAIN_RST = 32'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // cal codes: 0 input, 1 ground, 2 4.9V, 3 2.45V, 4 1.225V, 5 0.6125V
  typedef enum logic [2:0] {MODE_OFF = 3'b000, MODE_UCONT = 3'b001,
    MODE_USINGLE = 3'b010, MODE_BCONT = 3'b011, MODE_BSINGLE = 3'b100,
    MODE_EXT = 3'b101} asq_mode_t;
  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_START = 3'b001,
    ST_CONV = 3'b010, ST_GAP = 3'b011, ST_EXTW = 3'b100} asq_state_t;
  typedef struct packed {logic [11:0] addr; logic [31:0] data; logic [3:0] strb;} asq_wr_t;
  typedef struct packed {logic [4:0] chan; logic [1:0] gain; logic [2:0] cal;} asq_adc_sel_t;
endpackage

// >>> verilog/asq_timer.sv
// asq_timer: microsecond interval timer with one-cycle expiry pulse
`timescale 1ns/10ps
module asq_timer #(
  parameter int US_CYC = asq_pkg::US_CYC
) (
  // clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // load and expiry
  input wire logic load,
  input wire logic [asq_pkg::IVL_W-1:0] interval_us,
  output logic busy,
  output logic done
);
  import asq_pkg::*;
  logic [7:0] pre_q;
  logic [IVL_W-1:0] cnt_q;
  logic run_q;
  logic done_q;
  wire us_tick = run_q && (pre_q == 8'(US_CYC - 1));
  assign busy = run_q;
  assign done = done_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pre_q <= 8'h00;
      cnt_q <= '0;
      run_q <= 1'b0;
      done_q <= 1'b0;
    end else if (ce) begin
      done_q <= us_tick && (cnt_q <= IVL_W'(1));
      if (load) begin
        pre_q <= 8'h00;
        cnt_q <= interval_us;
        run_q <= 1'b1;
      end else if (us_tick) begin
        pre_q <= 8'h00;
        cnt_q <= cnt_q - IVL_W'(1);
        run_q <= cnt_q > IVL_W'(1);
      end else if (run_q) begin
        pre_q <= pre_q + 8'h01;
      end
    end
  end
endmodule

// >>> verilog/asq_axil.sv
// asq_axil: axi4-lite slave turning bus beats into register strobes
`timescale 1ns/10ps
module asq_axil (
  // clock and control
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register side
  output asq_pkg::asq_wr_t wr,
  output logic wr_en,
  input wire logic wr_err,
  output logic rd_en,
  output logic [11:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  import asq_pkg::*;
  logic aw_q, w_q, b_q, ar_q, f_q, r_q;
  logic [11:0] awa_q, ara_q;
  logic [31:0] wd_q, rd_q;
  logic [3:0] ws_q;
  logic [1:0] bresp_q, rresp_q;
  assign awready = ce & ~aw_q & ~b_q;
  assign wready = ce & ~w_q & ~b_q;
  assign wr_en = ce & aw_q & w_q & ~b_q;
  assign wr = '{addr: awa_q, data: wd_q, strb: ws_q};
  assign bvalid = b_q;
  assign bresp = bresp_q;
  // reads park in a one-word fetch buffer before the answer
  assign arready = ce & ~ar_q;
  assign rd_en = ce & f_q;
  assign rd_addr = ara_q;
  assign rvalid = r_q;
  assign rdata = rd_q;
  assign rresp = rresp_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {aw_q, w_q, b_q, ar_q, f_q, r_q} <= 6'h00;
      awa_q <= 12'h000;
      ara_q <= 12'h000;
      wd_q <= 32'h00000000;
      rd_q <= 32'h00000000;
      ws_q <= 4'h0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_q <= 1'b1;
        awa_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_q <= 1'b1;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (wr_en) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        b_q <= 1'b1;
        bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (b_q && bready) begin
        b_q <= 1'b0;
      end
      if (arvalid && arready) begin
        ar_q <= 1'b1;
        f_q <= 1'b1;
        ara_q <= araddr;
      end
      if (f_q) begin
        f_q <= 1'b0;
        r_q <= 1'b1;
        rd_q <= rd_data;
        rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (r_q && rready) begin
        r_q <= 1'b0;
        ar_q <= 1'b0;
      end
    end
  end
  sequence s_fetch;
    rd_en ##1 rvalid;
  endsequence
  a_read_fetch: assert property (@(posedge clock) disable iff (reset || !ce)
    arvalid && arready |=> s_fetch) else $error("read not answered from fetch buffer");
  a_write_resp: assert property (@(posedge clock) disable iff (reset || !ce)
    wr_en |=> bvalid && !awready && !wready) else $error("write response late");
endmodule

// >>> verilog/asq_top.sv
// asq_top: scan sequencer, mailbox, flags and register file
//
// How it works
// - conversion starts are never closer than 8 us apart
// - 32 mailboxes: two per differential channel or one per single-ended
// - interrupt after each conversion or after the whole group, selectable
// - scan walks channels in order from start to end inclusive
// - uniform modes wait one timer interval between conversions
// - burst continuous waits one interval between groups
// - interval timer covers 8 us up to about 2.09 s
// - uniform continuous cycles round robin until software stops it
// - burst continuous converts at 15 us per channel, repeats per interval
// - uniform single converts each channel once, interval spaced
// - burst single converts each channel once at 15 us spacing
// - external mode converts one channel per external trigger edge
// - trigger pin may be driven from the interval timer
// - per-channel gain of 1, 2, 4 or 8 applied at conversion
// - calibration reference selection is passed to the converter
// - new-data flag sets on fresh result, clears on read or scan
// - missed-data flag sets when an unread result is overwritten
// - missed-data flag clears on mailbox read or new scan
// - results read as straight binary or two's complement
// - bus slave only, single transfers with byte strobes
// - reads go through a fetch buffer before the answer
// - all interrupt sources share one bus interrupt line
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module asq_top #(
  parameter int IVL_MAX = asq_pkg::IVL_MAX_US
) (
  // clock, reset, enable
  input wire logic clock,
  input wire logic reset,
  input wire logic ce,
  // axi4-lite slave
  input wire logic awvalid,
  output logic awready,
  input wire logic [11:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [11:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // converter
  output logic adc_start,
  output asq_pkg::asq_adc_sel_t adc_sel,
  input wire logic adc_done,
  input wire logic [15:0] adc_data,
  // external trigger pin
  input wire logic trig_i,
  output logic trig_o,
  output logic trig_oe,
  // bus interrupt
  output logic irq_n
);
  import asq_pkg::*;

  asq_wr_t wr;
  logic wr_en, rd_en;
  logic [11:0] rd_addr;
  logic [31:0] rd_data;
  logic [31:0] ctrl_q, ivl_q, chan_q32, glo_q, ghi_q;
  logic pend_q;
  asq_state_t state_q, state_d;
  logic [4:0] chan_q, chan_d;
  logic [11:0] since_q;
  logic adc_start_q, trig_o_q;
  asq_adc_sel_t sel_q;
  logic [NCH-1:0] new_q, missed_q;
  logic [15:0] bank_q;
  logic [DW-1:0] mbox_q [NCH];
  logic t1_q, t2_q, t3_q;
  logic start_conv, gap_load, tmr_busy, tmr_done;

  function automatic logic [31:0] wmask(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[b*8 +: 8] = n[b*8 +: 8];
    end
    return r;
  endfunction

  function automatic logic reg_hit(input logic [11:0] a);
    return a == OFS_CTRL || a == OFS_IVL || a == OFS_CHAN || a == OFS_NEW ||
           a == OFS_MISS || a == OFS_CMD || a == OFS_GLO || a == OFS_GHI ||
           a == OFS_IRQ;
  endfunction

  // mailbox page decode, needed by the bus error check below
  wire rd_mbox = rd_addr[11:7] == MBOX_PAGE;

  asq_axil u_bus (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr(wr),
    .wr_en(wr_en),
    .wr_err(!reg_hit(wr.addr)),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_err(!(reg_hit(rd_addr) || rd_mbox))
  );

  // control fields
  wire asq_mode_t mode_q = asq_mode_t'(ctrl_q[CTRL_MODE_LSB +: 3]);
  wire se_q = ctrl_q[CTRL_SE];
  wire fmt_q = ctrl_q[CTRL_FMT];
  wire grp_q = ctrl_q[CTRL_GRP];
  wire ien_q = ctrl_q[CTRL_IEN];
  wire tout_q = ctrl_q[CTRL_TOUT];
  wire [2:0] cal_q = ctrl_q[CTRL_CAL_LSB +: 3];
  wire [4:0] start_ch = chan_q32[4:0];
  wire [4:0] end_ch = chan_q32[CHAN_END_LSB +: 5];
  wire [63:0] gain_all = {ghi_q, glo_q};

  // write decode
  wire ws_ctrl = wr_en && wr.addr == OFS_CTRL;
  wire ws_ivl = wr_en && wr.addr == OFS_IVL;
  wire ws_chan = wr_en && wr.addr == OFS_CHAN;
  wire ws_glo = wr_en && wr.addr == OFS_GLO;
  wire ws_ghi = wr_en && wr.addr == OFS_GHI;
  wire ws_cmd = wr_en && wr.addr == OFS_CMD && wr.strb[0];
  wire sw_go = ws_cmd && wr.data[CMD_GO];
  wire sw_stop = ws_cmd && wr.data[CMD_STOP];
  wire irq_clr = wr_en && wr.addr == OFS_IRQ && wr.strb[0] && wr.data[IRQ_PEND];

  // read decode; a fetch also acts as the host's read of a mailbox
  wire [4:0] rd_idx = rd_addr[6:2];
  wire [DW-1:0] mb_raw = mbox_q[rd_idx];
  wire [DW-1:0] mb_fmt = fmt_q ? {~mb_raw[DW-1], mb_raw[DW-2:0]} : mb_raw;
  wire [31:0] status = {24'h000000, chan_q, state_q};
  assign rd_data = rd_mbox ? {16'h0000, mb_fmt} :
                   rd_addr == OFS_CTRL ? ctrl_q :
                   rd_addr == OFS_IVL ? ivl_q :
                   rd_addr == OFS_CHAN ? chan_q32 :
                   rd_addr == OFS_NEW ? new_q :
                   rd_addr == OFS_MISS ? missed_q :
                   rd_addr == OFS_CMD ? status :
                   rd_addr == OFS_GLO ? glo_q :
                   rd_addr == OFS_GHI ? ghi_q :
                   rd_addr == OFS_IRQ ? {31'h00000000, pend_q} : 32'h00000000;

  // external trigger: two-flop synchroniser, edge taken past the second
  wire ext_edge = t2_q & ~t3_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {t1_q, t2_q, t3_q} <= 3'h0;
    end else if (ce) begin
      {t1_q, t2_q, t3_q} <= {trig_i, t1_q, t2_q};
    end
  end

  // interval clamped into the timer's range
  wire [31:0] ivl_hi = (ivl_q > 32'(IVL_MAX)) ? 32'(IVL_MAX) : ivl_q;
  wire [31:0] ivl_lim = (ivl_hi < 32'(IVL_MIN_US)) ? 32'(IVL_MIN_US) : ivl_hi;
  wire tmr_free = tout_q && !tmr_busy && state_q != ST_GAP;
  asq_timer u_tmr (
    .clock(clock),
    .reset(reset),
    .ce(ce),
    .load(gap_load || tmr_free),
    .interval_us(ivl_lim[IVL_W-1:0]),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // sequencer
  wire burst_m = mode_q == MODE_BCONT || mode_q == MODE_BSINGLE;
  wire [11:0] pace = burst_m ? BURST_CYC : CONV_MIN_CYC;
  wire last = chan_q == end_ch;
  wire conv_done = state_q == ST_CONV && adc_done;
  wire mode_ok = mode_q inside {MODE_UCONT, MODE_USINGLE, MODE_BCONT, MODE_BSINGLE};
  wire go = mode_q == MODE_EXT ? ext_edge : mode_ok && (sw_go || ext_edge);
  // scan cycle starts on a trigger from idle; clearing each round would hide overruns
  wire scan_start = state_q == ST_IDLE && go;

  always_comb begin
    state_d = state_q;
    chan_d = chan_q;
    start_conv = 1'b0;
    gap_load = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (go) begin
          chan_d = start_ch;
          state_d = ST_START;
        end
      end
      ST_START: begin
        if (since_q >= pace) begin
          start_conv = 1'b1;
          state_d = ST_CONV;
        end
      end
      ST_CONV: begin
        if (adc_done) begin
          chan_d = last ? start_ch : chan_q + 5'h01;
          case (mode_q)
            MODE_UCONT: begin
              gap_load = 1'b1;
              state_d = ST_GAP;
            end
            MODE_USINGLE: begin
              gap_load = !last;
              state_d = last ? ST_IDLE : ST_GAP;
            end
            MODE_BCONT: begin
              gap_load = last;
              state_d = last ? ST_GAP : ST_START;
            end
            MODE_BSINGLE: state_d = last ? ST_IDLE : ST_START;
            MODE_EXT: state_d = ST_EXTW;
            default: state_d = ST_IDLE;
          endcase
        end
      end
      ST_GAP: begin
        if (tmr_done) state_d = ST_START;
      end
      ST_EXTW: begin
        if (ext_edge) state_d = ST_START;
      end
      default: state_d = ST_IDLE;
    endcase
    if (sw_stop || mode_q == MODE_OFF) state_d = ST_IDLE;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      chan_q <= 5'h00;
      since_q <= 12'hFFF;
      adc_start_q <= 1'b0;
      sel_q <= '0;
      trig_o_q <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      chan_q <= chan_d;
      adc_start_q <= start_conv;
      trig_o_q <= tmr_done;
      if (start_conv) since_q <= 12'h001;
      else if (since_q != 12'hFFF) since_q <= since_q + 12'h001;
      if (start_conv) begin
        sel_q.chan <= chan_q;
        sel_q.gain <= gain_all[{chan_q, 1'b0} +: 2];
        sel_q.cal <= cal_q;
      end
    end
  end
  assign adc_start = adc_start_q;
  assign adc_sel = sel_q;
  assign trig_o = trig_o_q;
  assign trig_oe = tout_q;

  // mailbox placement: differential channels alternate two buffers
  wire mb_we = conv_done;
  wire [3:0] lo = sel_q.chan[3:0];
  wire [4:0] mb_idx = se_q ? sel_q.chan : {bank_q[lo], lo};
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bank_q <= 16'h0000;
    end else if (ce && mb_we && !se_q) begin
      bank_q[lo] <= ~bank_q[lo];
    end
  end

  for (genvar i = 0; i < NCH; i++) begin : g_mb
    wire set = mb_we && mb_idx == 5'(i);
    wire hrd = rd_en && rd_mbox && rd_idx == 5'(i);
    wire clr = hrd || scan_start;
    always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
        mbox_q[i] <= 16'h0000;
        new_q[i] <= 1'b0;
        missed_q[i] <= 1'b0;
      end else if (ce) begin
        if (set) mbox_q[i] <= adc_data;
        new_q[i] <= set || (new_q[i] && !clr);
        missed_q[i] <= (set && new_q[i] && !hrd) || (missed_q[i] && !clr);
      end
    end
  end

  // registers and interrupt
  wire irq_evt = ien_q && mb_we && (!grp_q || last);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RST;
      ivl_q <= IVL_RST;
      chan_q32 <= CHAN_RST;
      glo_q <= GAIN_RST;
      ghi_q <= GAIN_RST;
      pend_q <= 1'b0;
    end else if (ce) begin
      if (ws_ctrl) ctrl_q <= wmask(ctrl_q, wr.data, wr.strb);
      if (ws_ivl) ivl_q <= wmask(ivl_q, wr.data, wr.strb);
      if (ws_chan) chan_q32 <= wmask(chan_q32, wr.data, wr.strb);
      if (ws_glo) glo_q <= wmask(glo_q, wr.data, wr.strb);
      if (ws_ghi) ghi_q <= wmask(ghi_q, wr.data, wr.strb);
      pend_q <= irq_evt || (pend_q && !irq_clr);
    end
  end
  assign irq_n = ~pend_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset || !ce);
  sequence s_done_last;
    conv_done && last;
  endsequence

  a_conv_spacing: assert property (start_conv |-> since_q >= CONV_MIN_CYC)
    else $error("conversions too close");
  a_burst_pace: assert property (start_conv && burst_m |-> since_q >= BURST_CYC)
    else $error("burst pace under 15 us");
  a_chan_range: assert property (start_conv && start_ch <= end_ch |->
    chan_q >= start_ch && chan_q <= end_ch) else $error("channel out of range");
  a_chan_step: assert property (conv_done && !last |=> chan_q == $past(chan_q) + 5'h01)
    else $error("channel did not advance");
  a_gap_wait: assert property (conv_done && mode_q == MODE_UCONT && !sw_stop |=>
    state_q == ST_GAP) else $error("uniform gap skipped");
  a_single_end: assert property (s_done_last ##0 (mode_q inside {MODE_USINGLE,
    MODE_BSINGLE}) |=> state_q == ST_IDLE) else $error("single scan kept going");
  a_new_flag: assert property (mb_we |=> new_q[$past(mb_idx)])
    else $error("new-data flag not set");
  a_miss_flag: assert property (mb_we && new_q[mb_idx] && !rd_en |=>
    missed_q[$past(mb_idx)]) else $error("missed-data flag not set");
  a_scan_clear: assert property (scan_start |=> new_q == '0 && missed_q == '0)
    else $error("flags survived scan start");
  a_irq_group: assert property (s_done_last ##0 ien_q |=> !irq_n)
    else $error("group interrupt missing");
endmodule

// >>> dv/asq_adc_model.sv
// asq_adc_model: behavioural converter answering each start with one result
`timescale 1ns/10ps
module asq_adc_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // converter handshake
  input wire logic adc_start,
  input wire logic slow,
  input wire logic [15:0] sample,
  output logic adc_done,
  output logic [15:0] adc_data
);
  int cnt;
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt <= 0;
      adc_done <= 1'b0;
      adc_data <= 16'h0000;
    end else begin
      adc_done <= 1'b0;
      // data bus is only valid in the done cycle, so it toggles elsewhere
      adc_data <= ~adc_data;
      if (adc_start) begin
        cnt <= slow ? 900 : 5;
      end else if (cnt == 1) begin
        adc_done <= 1'b1;
        adc_data <= sample;
        cnt <= 0;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// >>> dv/asq_top_tb.sv
// asq_top_tb: self-checking bench for the analog scan sequencer
`timescale 1ns/10ps
module asq_top_tb;
  import asq_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, adc_start, adc_done;
  logic trig_o, trig_oe, irq_n, slow = 1'b0, trig_i = 1'b0;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] adc_data, sample = 16'h0;
  asq_adc_sel_t adc_sel;
  int n_fail = 0, checks = 0, ndone = 0, gap = 100000, min_gap = 1000, cur = 0, k;
  int exp_ch[$];
  logic [15:0] mbox [32];
  logic [63:0] gains;
  logic [2:0] cal_e = 3'h0;
  logic [31:0] rs = 32'h00002AD8; // seed 10968

  always #4 clock = ~clock;

  asq_top #(.IVL_MAX(20)) DUT (.clock, .reset, .ce, .awvalid, .awready, .awaddr, .wvalid,
    .wready, .wdata, .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .adc_start, .adc_sel, .adc_done, .adc_data,
    .trig_i, .trig_o, .trig_oe, .irq_n);
  asq_adc_model adc (.clock, .reset, .adc_start, .slow, .sample, .adc_done, .adc_data);

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", 32'(er), 32'(bresp));
    bready <= 1'b0;
  endtask

  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clock);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    chk(nm, e, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    rready <= 1'b0;
  endtask

  task automatic wt(input int t);
    int n;
    n = 0;
    while (ndone < t && n < 20000) begin
      @(posedge clock);
      n++;
    end
    chk("done_count", 32'(t), 32'(ndone));
    repeat (3) @(posedge clock);
  endtask

  task wrap_up();
    if (n_fail == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // stimulus source and reference model of the scan
  always @(posedge clock) begin
    rs <= xs(rs);
    sample <= rs[15:0];
    gap <= gap + 1;
    if (adc_start) begin
      gap <= 1;
      chk("spacing_ok", 32'h1, 32'(gap >= min_gap));
      if (exp_ch.size() == 0) begin
        chk("start_expected", 32'h0, 32'h1);
      end else begin
        chk("chan", 32'(exp_ch.pop_front()), 32'(adc_sel.chan));
      end
      chk("gain", 32'(gains[2 * adc_sel.chan +: 2]), 32'(adc_sel.gain));
      chk("cal", 32'(cal_e), 32'(adc_sel.cal));
      cur <= adc_sel.chan;
    end
    if (adc_done) begin
      mbox[cur] <= adc_data;
      ndone <= ndone + 1;
    end
  end

  initial begin
    gains = {xs(32'h00002AD8), 32'h00002AD8};
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd("ctrl_rst", OFS_CTRL, CTRL_RST, RESP_OKAY);
    rd("ivl_rst", OFS_IVL, IVL_RST, RESP_OKAY);
    rd("chan_rst", OFS_CHAN, CHAN_RST, RESP_OKAY);
    rd("unmapped", 12'h040, 32'h0, RESP_SLVERR);
    wr(12'h040, 32'h1, RESP_SLVERR);
    wr(12'h084, 32'h1, RESP_SLVERR);
    wr(OFS_GLO, gains[31:0], RESP_OKAY);
    wr(OFS_GHI, gains[63:32], RESP_OKAY);
    // burst single, group interrupt, slow converter
    cal_e = 3'h2;
    min_gap = 1875;
    slow <= 1'b1;
    wr(OFS_CTRL, 32'h0000026C, RESP_OKAY);
    wr(OFS_CHAN, 32'h00000402, RESP_OKAY);
    exp_ch = {2, 3, 4};
    wr(OFS_CMD, 32'h1, RESP_OKAY);
    wt(ndone + 1);
    chk("irq_n_mid_group", 32'h1, 32'(irq_n));
    wt(ndone + 2);
    chk("irq_n_group", 32'h0, 32'(irq_n));
    chk("queue_left", 32'h0, 32'(exp_ch.size()));
    rd("new_flags", OFS_NEW, 32'h0000001C, RESP_OKAY);
    rd("irq_pend", OFS_IRQ, 32'h1, RESP_OKAY);
    wr(OFS_IRQ, 32'h1, RESP_OKAY);
    chk("irq_n_clear", 32'h1, 32'(irq_n));
    for (int i = 2; i < 5; i++) begin
      rd("mbox", 12'h080 + 12'(4 * i), {16'h0, mbox[i]}, RESP_OKAY);
    end
    rd("new_after_read", OFS_NEW, 32'h0, RESP_OKAY);
    // uniform single, two's complement, per-channel interrupt
    cal_e = 3'h0;
    min_gap = 1000;
    slow <= 1'b0;
    wr(OFS_CTRL, 32'h0000005A, RESP_OKAY);
    wr(OFS_CHAN, 32'h00001F1E, RESP_OKAY);
    exp_ch = {30, 31};
    wr(OFS_CMD, 32'h1, RESP_OKAY);
    wt(ndone + 1);
    chk("irq_n_chan", 32'h0, 32'(irq_n));
    wt(ndone + 1);
    rd("mbox_twos", 12'h0F8, {16'h0, mbox[30] ^ 16'h8000}, RESP_OKAY);
    wr(OFS_IRQ, 32'h1, RESP_OKAY);
    // uniform then burst continuous, two rounds each, stopped by software
    for (int m = 1; m < 4; m += 2) begin
      min_gap = (m == 3) ? 1875 : 1000;
      wr(OFS_CTRL, 32'h00000008 | 32'(m), RESP_OKAY);
      wr(OFS_CHAN, 32'h00000807, RESP_OKAY);
      exp_ch = {7, 8, 7, 8};
      wr(OFS_CMD, 32'h1, RESP_OKAY);
      wt(ndone + 4);
      wr(OFS_CMD, 32'h2, RESP_OKAY);
      repeat (2000) @(posedge clock);
      chk("queue_left", 32'h0, 32'(exp_ch.size()));
      rd("missed_cont", OFS_MISS, 32'h00000180, RESP_OKAY);
    end
    min_gap = 1000;
    // external trigger only, wraps after the end channel
    wr(OFS_CTRL, 32'h0000000D, RESP_OKAY);
    wr(OFS_CHAN, 32'h00000605, RESP_OKAY);
    exp_ch = {5, 6, 5};
    k = ndone + 3;
    repeat (3) begin
      trig_i <= 1'b1;
      repeat (4) @(posedge clock);
      trig_i <= 1'b0;
      repeat (1500) @(posedge clock);
    end
    wt(k);
    chk("queue_left", 32'h0, 32'(exp_ch.size()));
    rd("new_wrap", OFS_NEW, 32'h00000060, RESP_OKAY);
    rd("missed_wrap", OFS_MISS, 32'h00000020, RESP_OKAY);
    rd("mbox_ext", 12'h094, {16'h0, mbox[5]}, RESP_OKAY);
    rd("missed_read", OFS_MISS, 32'h00000000, RESP_OKAY);
    // trigger pin driven by the interval timer
    wr(OFS_IVL, 32'h0000000A, RESP_OKAY);
    wr(OFS_CTRL, 32'h00000080, RESP_OKAY);
    chk("trig_oe", 32'h1, 32'(trig_oe));
    k = 0;
    repeat (3000) begin
      @(posedge clock);
      if (trig_o) k++;
    end
    chk("trig_pulses_ok", 32'h1, 32'(k >= 2 && k <= 3));
    // enable low must refuse every bus beat
    ce <= 1'b0;
    repeat (3) @(posedge clock);
    chk("ready_ce_low", 32'h0, 32'({awready, wready, arready}));
    ce <= 1'b1;
    @(posedge clock);
    wrap_up();
  end

  initial begin
    #(8 * 60000);
    n_fail++;
    $display("[ERR] watchdog exp finish got timeout");
    wrap_up();
  end
endmodule
